// file: hdl/pfs_pkg.sv
// Package for the fault status flag block: offsets, field positions, types.
package pfs_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_STATUS     = 8'h0C;
	localparam logic [7:0]  IDX_MASK       = 8'h0D;
	localparam logic [7:0]  IDX_IRQ_STAT   = 8'h30;
	localparam logic [7:0]  IDX_IRQ_MASK   = 8'h31;
	localparam logic [7:0]  IDX_CONTROL    = 8'h32;
	localparam logic [7:0]  IDX_MODE       = 8'h33;
	localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] ADDR_MASK      = {2'h0, IDX_MASK, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STAT  = {2'h0, IDX_IRQ_STAT, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK  = {2'h0, IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] ADDR_CONTROL   = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_MODE      = {2'h0, IDX_MODE, 2'h0};

	// Flag bit positions
	localparam int BIT_LED_OVP   = 7;
	localparam int BIT_SIX_PGF   = 6;
	localparam int BIT_PROJ_LOW  = 5;
	localparam int BIT_MIRR_FLT  = 4;
	localparam int BIT_UNDERVOLTAGE_LOCKOUT_FLAG      = 3;
	localparam int BIT_LOW_BATTERY_WARNING_FLAG   = 2;
	localparam int BIT_TSD       = 1;
	localparam int BIT_HOT       = 0;
	localparam int NUM_FLAGS     = 8;

	// Reset values and bus answers
	localparam logic [7:0]  MASK_RESET     = 8'h00;
	localparam logic [7:0]  FLAGS_ZERO     = 8'h00;
	localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// Lockout delay before entering the reset state
	localparam int CLOCK_MHZ     = 125;
	localparam int UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_MS = 25;
	localparam int UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_CYC = UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_MS * 1000 * CLOCK_MHZ;
	localparam int CNT_W         = 22;

	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_STANDBY,
		MODE_OFF,
		MODE_RESET
	} pfs_mode_t;

	// Live analog conditions from comparators
	typedef struct packed {
		logic ledOverVolt;
		logic sixVoltOutOfReg;
		logic projectorOnPin;
		logic inductorSlow;
		logic regBelowGood;
		logic batBelowUvlo;
		logic batBelowLow;
		logic dieAboveTsd;
		logic dieCoolTsd;
		logic dieAboveHot;
		logic dieCoolHot;
	} pfs_cond_t;

	// AXI4-Lite slave side signals
	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} pfs_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pfs_axi_rsp_t;

endpackage : pfs_pkg

// file: hdl/pfs_flag_unit.sv
// Per-flag hysteresis latch for thermal flags.
`timescale 1ns/1ps
module pfs_flag_unit (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic setCond,
	input  wire logic coolCond,
	output logic      flag
);
	import pfs_pkg::*;

	typedef struct packed {
		logic held;
	} pfs_fu_state_t;

	pfs_fu_state_t state_ff;
	pfs_fu_state_t nxt_state;

	// Set while hot, held until the die is cool enough to recover
	always_comb begin
		nxt_state = state_ff;
		if (setCond) begin
			nxt_state.held = 1'b1;
		end else if (coolCond) begin
			nxt_state.held = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Live condition shows at once; the latch only extends it
	assign flag = setCond | state_ff.held;

	AST_HOLD_UNTIL_COOL: assert property (@(posedge clock) disable iff (srst)
		(flag && !setCond && !coolCond) |=> flag)
		else $error("flag dropped before cooling");

endmodule : pfs_flag_unit

// file: hdl/pfs_fault_flags.sv
// Fault status flags, mirror regulator mode control and AXI4-Lite registers.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Read-only eight-bit fault status at index 0x0C; no value promised before reading.
// - Bit 7 follows LED converter overvoltage; operation continues.
// - Bit 6 follows six-volt rail out of regulation; operation continues.
// - Bit 5 is one while projector-on pin is low; chip enters OFF.
// - Mirror regulator fault forces STANDBY and clears the regulator enable.
// - Mirror fault raised on slow inductor current or output below power-good.
// - Bit 3 follows undervoltage lockout; lockout clears regulator enable.
// - Bit 2 follows low-battery warning; operation continues.
// - Thermal shutdown forces STANDBY, regulator enable left unchanged.
// - Bit 0 is thermal warning, held until die cools; operation continues.
// - Mask at index 0x0D, same layout; set bit keeps flag off the pin.
module pfs_fault_flags #(
	parameter int UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES = pfs_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_CYC
) (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire pfs_pkg::pfs_cond_t    cond,
	input  wire pfs_pkg::pfs_axi_req_t axiReq,
	output pfs_pkg::pfs_axi_rsp_t      axiRsp,
	output logic [7:0]                 faultStatus,
	output logic                       mirrorRegEnable,
	output pfs_pkg::pfs_mode_t         chipMode,
	output logic                       serialEnable,
	output logic                       interruptOut_n,
	output logic                       irq
);
	import pfs_pkg::*;

	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  mask;
		logic [7:0]  evtStat;
		logic [7:0]  evtMask;
		logic        mirrEn;
		pfs_mode_t   mode;
		logic        uvloWait;
		logic [CNT_W-1:0] uvloCnt;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pfs_state_t;

	pfs_state_t state_ff;
	pfs_state_t nxt_state;
	logic [7:0] liveFlags;
	logic       tsdFlag;
	logic       hotFlag;
	logic       wrFire;
	logic       rdFire;
	logic [7:0] riseFlags;

	// Address decoding shared by read and write paths
	function automatic logic isMapped(input logic [11:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr == ADDR_STATUS) begin
			hit = 1'b1;
		end else if (addr == ADDR_MASK) begin
			hit = 1'b1;
		end else if (addr == ADDR_IRQ_STAT) begin
			hit = 1'b1;
		end else if (addr == ADDR_IRQ_MASK) begin
			hit = 1'b1;
		end else if (addr == ADDR_CONTROL) begin
			hit = 1'b1;
		end else if (addr == ADDR_MODE) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : isMapped

	// Thermal flags carry hysteresis
	pfs_flag_unit uTsd (
		.clock    (clock),
		.srst     (srst),
		.setCond  (cond.dieAboveTsd),
		.coolCond (cond.dieCoolTsd),
		.flag     (tsdFlag)
	);

	pfs_flag_unit uHot (
		.clock    (clock),
		.srst     (srst),
		.setCond  (cond.dieAboveHot),
		.coolCond (cond.dieCoolHot),
		.flag     (hotFlag)
	);

	// Live flag vector, registered once so the bus sees a clean value
	always_comb begin
		liveFlags = FLAGS_ZERO;
		liveFlags[BIT_LED_OVP]  = cond.ledOverVolt;
		liveFlags[BIT_SIX_PGF]  = cond.sixVoltOutOfReg;
		liveFlags[BIT_PROJ_LOW] = ~cond.projectorOnPin;
		liveFlags[BIT_MIRR_FLT] = cond.inductorSlow | cond.regBelowGood;
		liveFlags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG]     = cond.batBelowUvlo;
		liveFlags[BIT_LOW_BATTERY_WARNING_FLAG]  = cond.batBelowLow;
		liveFlags[BIT_TSD]      = tsdFlag;
		liveFlags[BIT_HOT]      = hotFlag;
	end

	// Bus is taken in every mode, the lockout reset state included
	assign wrFire = axiReq.awvalid & axiReq.wvalid & ~state_ff.bvalid;
	assign rdFire = axiReq.arvalid & ~state_ff.rvalid;

	// Rising edge of each flag marks an event; shared by the event logic and its check
	assign riseFlags = liveFlags & ~state_ff.flags;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.flags = liveFlags;
		// Events: rising edge of each flag; set wins over a write-one clear
		if (wrFire && axiReq.awaddr == ADDR_IRQ_STAT && axiReq.wstrb[0]) begin
			nxt_state.evtStat = state_ff.evtStat & ~axiReq.wdata[7:0];
		end
		nxt_state.evtStat = nxt_state.evtStat | riseFlags;

		// Write channel: address and data taken together
		if (state_ff.bvalid && axiReq.bready) begin
			nxt_state.bvalid = 1'b0;
		end
		if (wrFire) begin
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp  = isMapped(axiReq.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (axiReq.wstrb[0]) begin
				if (axiReq.awaddr == ADDR_MASK) begin
					nxt_state.mask = axiReq.wdata[7:0];
				end else if (axiReq.awaddr == ADDR_IRQ_MASK) begin
					nxt_state.evtMask = axiReq.wdata[7:0];
				end else if (axiReq.awaddr == ADDR_CONTROL) begin
					nxt_state.mirrEn = axiReq.wdata[0];
				end
			end
		end

		// Read channel
		if (state_ff.rvalid && axiReq.rready) begin
			nxt_state.rvalid = 1'b0;
		end
		if (rdFire) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp  = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
			nxt_state.rdata  = DATA_ZERO;
			if (axiReq.araddr == ADDR_STATUS) begin
				nxt_state.rdata[7:0] = state_ff.flags;
			end else if (axiReq.araddr == ADDR_MASK) begin
				nxt_state.rdata[7:0] = state_ff.mask;
			end else if (axiReq.araddr == ADDR_IRQ_STAT) begin
				nxt_state.rdata[7:0] = state_ff.evtStat;
			end else if (axiReq.araddr == ADDR_IRQ_MASK) begin
				nxt_state.rdata[7:0] = state_ff.evtMask;
			end else if (axiReq.araddr == ADDR_CONTROL) begin
				nxt_state.rdata[0] = state_ff.mirrEn;
			end else if (axiReq.araddr == ADDR_MODE) begin
				nxt_state.rdata[1:0] = state_ff.mode;
			end
		end

		// Mode control; faults override software, lockout overrides all
		if (state_ff.mode != MODE_RESET) begin
			if (!cond.projectorOnPin) begin
				nxt_state.mode = MODE_OFF;
			end else if (liveFlags[BIT_MIRR_FLT] || liveFlags[BIT_TSD]) begin
				nxt_state.mode = MODE_STANDBY;
			end else begin
				nxt_state.mode = MODE_ACTIVE;
			end
		end
		if (liveFlags[BIT_MIRR_FLT]) begin
			nxt_state.mirrEn = 1'b0;
		end
		if (liveFlags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG]) begin
			nxt_state.mirrEn = 1'b0;
		end

		// Lockout timer, started on the flag and run to the end
		if (liveFlags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] && !state_ff.uvloWait && state_ff.mode != MODE_RESET) begin
			nxt_state.uvloWait = 1'b1;
			nxt_state.uvloCnt  = '0;
		end else if (state_ff.uvloWait) begin
			if (state_ff.uvloCnt == CNT_W'(UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES - 1)) begin
				nxt_state.uvloWait = 1'b0;
				nxt_state.mode     = MODE_RESET;
			end else begin
				nxt_state.uvloCnt = state_ff.uvloCnt + CNT_W'(1);
			end
		end
	end

	// Single state register; reset state left only by the chip reset
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff      <= '0;
			state_ff.mask <= MASK_RESET;
			state_ff.mode <= MODE_ACTIVE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Ready is offered whenever a request is taken, whether serial access is alive or not
	assign serialEnable   = (state_ff.mode != MODE_RESET);
	assign axiRsp.awready = wrFire & axiReq.awvalid;
	assign axiRsp.wready  = wrFire;
	assign axiRsp.bvalid  = state_ff.bvalid;
	assign axiRsp.bresp   = state_ff.bresp;
	assign axiRsp.arready = rdFire;
	assign axiRsp.rvalid  = state_ff.rvalid;
	assign axiRsp.rdata   = state_ff.rdata;
	assign axiRsp.rresp   = state_ff.rresp;

	assign faultStatus     = state_ff.flags;
	assign mirrorRegEnable = state_ff.mirrEn;
	assign chipMode        = state_ff.mode;
	// Pin low for any unmasked flag; level, follows the registered flags
	assign interruptOut_n  = ~|(state_ff.flags & ~state_ff.mask);
	assign irq             = |(state_ff.evtStat & state_ff.evtMask);

	sequence s_uvloRise;
		!state_ff.flags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] ##1 state_ff.flags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG];
	endsequence

	// Status trails the live flags by one edge; the edge after reset still shows zero
	AST_STATUS_FOLLOWS: assert property (@(posedge clock) disable iff (srst)
		!$past(srst) |-> faultStatus == $past(liveFlags))
		else $error("status not tracking live flags");
	AST_LED_OVP: assert property (@(posedge clock) disable iff (srst)
		cond.ledOverVolt |=> faultStatus[BIT_LED_OVP])
		else $error("overvoltage flag missing");
	AST_SIX_PGF: assert property (@(posedge clock) disable iff (srst)
		!cond.sixVoltOutOfReg |=> !faultStatus[BIT_SIX_PGF])
		else $error("rail flag set without cause");
	AST_SIX_PGF_SET: assert property (@(posedge clock) disable iff (srst)
		cond.sixVoltOutOfReg |=> faultStatus[BIT_SIX_PGF])
		else $error("rail flag missing");

	// Mode checks skip the lockout wait, whose end overrides every other mode
	AST_PROJ_OFF: assert property (@(posedge clock) disable iff (srst)
		(!cond.projectorOnPin && chipMode != MODE_RESET && !state_ff.uvloWait) |=>
		faultStatus[BIT_PROJ_LOW] && chipMode == MODE_OFF)
		else $error("projector-on low not handled");
	AST_MIRR_STANDBY: assert property (@(posedge clock) disable iff (srst)
		(cond.regBelowGood && cond.projectorOnPin && chipMode != MODE_RESET
		&& !state_ff.uvloWait) |=> chipMode == MODE_STANDBY && !mirrorRegEnable)
		else $error("mirror fault did not force standby");
	AST_MIRR_CAUSE: assert property (@(posedge clock) disable iff (srst)
		cond.inductorSlow |=> faultStatus[BIT_MIRR_FLT])
		else $error("slow inductor not flagged");
	AST_UNDERVOLTAGE_LOCKOUT_FLAG_EN: assert property (@(posedge clock) disable iff (srst)
		cond.batBelowUvlo |=> !mirrorRegEnable)
		else $error("lockout left regulator enabled");

	// Lockout sequence: no early reset state, exact end of the wait, no way back
	AST_UNDERVOLTAGE_LOCKOUT_FLAG_NOT_EARLY: assert property (@(posedge clock) disable iff (srst)
		s_uvloRise |-> serialEnable [*8])
		else $error("reset state entered too early");
	AST_UNDERVOLTAGE_LOCKOUT_FLAG_RESET: assert property (@(posedge clock) disable iff (srst)
		(state_ff.uvloWait && state_ff.uvloCnt == CNT_W'(UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES - 1)) |=>
		chipMode == MODE_RESET && !serialEnable)
		else $error("reset state not entered after lockout wait");
	AST_RESET_STAYS: assert property (@(posedge clock) disable iff (srst)
		chipMode == MODE_RESET |=> chipMode == MODE_RESET)
		else $error("reset state left without chip reset");

	AST_LOW_BATTERY_WARNING_FLAG: assert property (@(posedge clock) disable iff (srst)
		cond.batBelowLow |=> faultStatus[BIT_LOW_BATTERY_WARNING_FLAG])
		else $error("low battery flag missing");
	// A warning alone must not touch the enable; writes and real faults excluded
	AST_LOW_BATTERY_WARNING_FLAG_RUNS: assert property (@(posedge clock) disable iff (srst)
		(cond.batBelowLow && !wrFire && !liveFlags[BIT_MIRR_FLT] && !liveFlags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG])
		|=> $stable(mirrorRegEnable))
		else $error("low battery changed regulator enable");
	AST_TSD_KEEP_EN: assert property (@(posedge clock) disable iff (srst)
		(cond.dieAboveTsd && !liveFlags[BIT_MIRR_FLT] && !liveFlags[BIT_UNDERVOLTAGE_LOCKOUT_FLAG]
		&& !wrFire && cond.projectorOnPin && chipMode != MODE_RESET && !state_ff.uvloWait)
		|=> chipMode == MODE_STANDBY && mirrorRegEnable == $past(mirrorRegEnable))
		else $error("thermal shutdown handling wrong");
	AST_HOT: assert property (@(posedge clock) disable iff (srst)
		cond.dieAboveHot |=> faultStatus[BIT_HOT])
		else $error("thermal warning missing");

	// Pin judged against the live flags, not the register it is built from
	AST_MASK_GATES: assert property (@(posedge clock) disable iff (srst)
		(!$past(srst) && (($past(liveFlags) & ~state_ff.mask) == FLAGS_ZERO))
		|-> interruptOut_n)
		else $error("masked flag pulled interrupt low");
	AST_INT_LOW: assert property (@(posedge clock) disable iff (srst)
		(|(liveFlags & ~state_ff.mask) && !wrFire) |=> !interruptOut_n)
		else $error("unmasked flag did not assert interrupt");

	// Event latch: a rising flag always lands, even against a clear
	AST_EVT_SET_WINS: assert property (@(posedge clock) disable iff (srst)
		(riseFlags != FLAGS_ZERO) |=> (state_ff.evtStat & $past(riseFlags)) == $past(riseFlags))
		else $error("flag event lost");

	// Bus answers one cycle after taking; unmapped reads answer error and zero
	AST_WRITE_ANSWER: assert property (@(posedge clock) disable iff (srst)
		wrFire |=> axiRsp.bvalid)
		else $error("write response missing");
	AST_READ_ANSWER: assert property (@(posedge clock) disable iff (srst)
		rdFire |=> axiRsp.rvalid)
		else $error("read response missing");
	AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (srst)
		(rdFire && !isMapped(axiReq.araddr)) |=> axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == DATA_ZERO)
		else $error("unmapped read answered wrongly");

endmodule : pfs_fault_flags

// file: tb/pfs_host_model.sv
// Display controller model: AXI4-Lite master reaching the flag registers.
`timescale 1ns/1ps
module pfs_host_model (
	input  wire pfs_pkg::pfs_axi_rsp_t rsp,
	input  wire logic                  clock,
	output pfs_pkg::pfs_axi_req_t      req
);
	import pfs_pkg::*;

	// Response ready stays high; the slave may answer whenever it likes
	initial begin
		req = '0;
		req.bready = 1'b1;
		req.rready = 1'b1;
	end

	// Address and data offered together, both released once both are taken
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.awaddr  <= a;
		req.wdata   <= d;
		req.wstrb   <= 4'hF;
		do @(posedge clock); while (!(rsp.awready === 1'b1 && rsp.wready === 1'b1));
		req.awvalid <= 1'b0;
		req.wvalid  <= 1'b0;
		req.wdata   <= ~d; // Stale data must not look valid
		do @(posedge clock); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
	endtask : axiWrite

	// Single read; waits on the slave with no assumed latency
	task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		do @(posedge clock); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		req.araddr  <= ~a;
		do @(posedge clock); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask : axiRead
endmodule : pfs_host_model

// file: tb/pfs_fault_flags_test.sv
// Self-checking testbench for the fault status flag block.
`timescale 1ns/1ps
module pfs_fault_flags_test;
	import pfs_pkg::*;
	localparam int          UNDERVOLTAGE_LOCKOUT_FLAG_SIM = 20; // Short lockout delay keeps the run brief
	localparam logic [10:0] IDLE     = 11'h105; // Pin high, die cooled, no faults
	logic         clock;
	logic         srst;
	pfs_cond_t    cond;
	pfs_axi_req_t axiReq;
	pfs_axi_rsp_t axiRsp;
	logic [7:0]   faultStatus;
	logic         mirrorRegEnable;
	pfs_mode_t    chipMode;
	logic         serialEnable;
	logic         interruptOut_n;
	logic         irq;
	int           fails;
	int           check_count;
	logic [31:0]  rdData;
	logic [31:0]  expMode;
	logic [1:0]   resp;
	// Condition vector raising flag b alone; entry 3 unused
	logic [10:0]  raise [8] = '{11'h107, 11'h10D, 11'h115, 11'h105,
		11'h185, 11'h005, 11'h305, 11'h505};

	pfs_fault_flags #(.UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES(UNDERVOLTAGE_LOCKOUT_FLAG_SIM)) i_dut (.clock(clock), .srst(srst), .cond(cond),
		.axiReq(axiReq), .axiRsp(axiRsp), .faultStatus(faultStatus),
		.mirrorRegEnable(mirrorRegEnable), .chipMode(chipMode), .serialEnable(serialEnable),
		.interruptOut_n(interruptOut_n), .irq(irq));
	pfs_host_model i_host (.rsp(axiRsp), .clock(clock), .req(axiReq));

	// Free-running clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tally_and_finish;
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_host.axiWrite(a, d, resp);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		i_host.axiRead(a, rdData, resp);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
		chk("rdata", e, rdData);
	endtask : rd

	// Conditions change on an edge, then flags and mode get time to settle
	task automatic apply(input logic [10:0] v);
		@(posedge clock);
		cond <= v;
		repeat (5) @(posedge clock);
	endtask : apply

	// Hang guard, well beyond the expected run
	initial begin
		repeat (6000) @(posedge clock);
		fails++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		fails = 0;
		check_count = 0;
		srst = 1'b1;
		cond = IDLE;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		repeat (2) @(posedge clock);
		chk("intOut", 32'h1, {31'h0, interruptOut_n});
		rd(ADDR_MASK, DATA_ZERO);
		rd(ADDR_STATUS, DATA_ZERO);
		wr(ADDR_IRQ_MASK, 32'h0000_00FF);
		// Each flag but the lockout flag alone: status bit, pin low, masked, unmasked
		for (int b = 0; b < NUM_FLAGS; b++) begin
			if (b != BIT_UNDERVOLTAGE_LOCKOUT_FLAG) begin
				apply(raise[b]);
				rd(ADDR_STATUS, 32'h1 << b);
				chk("intOut", 32'h0, {31'h0, interruptOut_n});
				expMode = {30'h0, MODE_ACTIVE};
				if (b == BIT_PROJ_LOW) expMode = {30'h0, MODE_OFF};
				else if (b == BIT_TSD || b == BIT_MIRR_FLT) expMode = {30'h0, MODE_STANDBY};
				chk("modeEach", expMode, {30'h0, chipMode});
				wr(ADDR_MASK, 32'h1 << b);
				repeat (2) @(posedge clock);
				chk("intOutMasked", 32'h1, {31'h0, interruptOut_n});
				wr(ADDR_MASK, DATA_ZERO);
				apply(IDLE);
			end
		end
		rd(ADDR_IRQ_STAT, 32'h0000_00F7);
		chk("irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STAT, 32'h0000_00FF);
		repeat (2) @(posedge clock);
		chk("irqClr", 32'h0, {31'h0, irq});
		// Shutdown keeps the enable, hysteresis holds the flag
		wr(ADDR_CONTROL, 32'h1);
		apply(11'h10A);
		chk("mode", {30'h0, MODE_STANDBY}, {30'h0, chipMode});
		chk("enable", 32'h1, {31'h0, mirrorRegEnable});
		apply(11'h100);
		rd(ADDR_STATUS, 32'h0000_0003);
		apply(IDLE);
		rd(ADDR_STATUS, DATA_ZERO);
		// Regulator output below good forces standby and clears the enable
		apply(11'h145);
		rd(ADDR_STATUS, 32'h0000_0010);
		chk("mode", {30'h0, MODE_STANDBY}, {30'h0, chipMode});
		chk("enable", 32'h0, {31'h0, mirrorRegEnable});
		apply(IDLE);
		apply(11'h005);
		chk("mode", {30'h0, MODE_OFF}, {30'h0, chipMode});
		apply(IDLE);
		wr(ADDR_STATUS, 32'h0000_00FF);
		rd(ADDR_STATUS, DATA_ZERO);
		i_host.axiRead(12'h200, rdData, resp);
		chk("unmappedResp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmappedData", DATA_ZERO, rdData);
		// Lockout clears the enable, then reset state after the delay
		wr(ADDR_CONTROL, 32'h1);
		apply(11'h125);
		chk("enable", 32'h0, {31'h0, mirrorRegEnable});
		chk("modeWait", {30'h0, MODE_ACTIVE}, {30'h0, chipMode});
		repeat (UNDERVOLTAGE_LOCKOUT_FLAG_SIM) @(posedge clock);
		chk("mode", {30'h0, MODE_RESET}, {30'h0, chipMode});
		chk("serialEn", 32'h0, {31'h0, serialEnable});
		rd(ADDR_STATUS, 32'h0000_0008);
		tally_and_finish();
	end
endmodule : pfs_fault_flags_test
